/* File: verilog/daa_status_chain_regs.sv */
module daa_status_chain_regs (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    output logic             IRQ_O,
    input  wire logic        SCLK_I,
    input  wire logic        LINK_FAULT_I,
    input  wire logic        FRAME_LOCK_I,
    input  wire logic [3:0]  LOOP_CURRENT_I,
    input  wire logic        INTL_SUPPORT_I,
    input  wire logic [3:0]  LINE_REV_I,
    input  wire logic        RING_I,
    input  wire logic [1:0]  SERIAL_MODE_I,
    input  wire logic [2:0]  RX_GAIN_FIELD_I,
    input  wire logic [2:0]  TX_ATTEN_FIELD_I,
    input  wire logic [15:0] RX_WORD_I,
    output logic      [15:0] SERIAL_OUT_DATA_O,
    output logic      [3:0]  RX_GAIN_DB_O,
    output logic      [3:0]  TX_ATTEN_DB_O,
    output logic             FSYNC_O,
    input  wire logic        RING_DETECT_PIN_I,
    output logic             RING_DETECT_PIN_O,
    output logic             RING_DETECT_PIN_OE_O,
    output logic             DELAYED_SYNC_PIN_O,
    output logic             FRAME_CTRL_O
);
    import daa_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int PIN_W = 16;

    logic [PIN_W-1:0] pins_s;
    logic             sclk_s;
    logic             fault_s;
    logic             lock_s;
    logic [3:0]       loop_s;
    logic             intl_s;
    logic [3:0]       rev_s;
    logic             ring_s;
    logic [1:0]       mode_s;
    logic             fctrl_s;

    daa_pin_sync #(.WIDTH(PIN_W)) u_sync (
        .clk_i  (CLOCK_I),
        .rstn_i (RSTN_I),
        .d_i    ({SCLK_I, LINK_FAULT_I, FRAME_LOCK_I, LOOP_CURRENT_I, INTL_SUPPORT_I,
                  LINE_REV_I, RING_I, SERIAL_MODE_I, RING_DETECT_PIN_I}),
        .q_o    (pins_s)
    );

    assign {sclk_s, fault_s, lock_s, loop_s, intl_s, rev_s, ring_s, mode_s, fctrl_s} = pins_s;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        init_state_t      fsm;
        logic [1:0]       strap_cnt;
        logic [7:0]       rdata;
        logic             link_err;
        logic [1:0]       legacy;
        logic [7:0]       chain;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic             lock_prev;
        logic             ring_prev;
        logic             sclk_prev;
        logic [4:0]       bitcnt;
        logic [2:0]       slot;
        logic             fsync;
        logic             dsync;
        logic [15:0]      out_word;
        logic [3:0]       rx_db;
        logic [3:0]       tx_db;
        logic             ring_pin;
        logic             ring_oe;
        logic             dsync_pin;
        logic             fctrl;
    } regs_state_t;

    regs_state_t st_r;
    regs_state_t st_nxt;

    // Extended field decode: top bit saturates at the largest step
    function automatic logic [3:0] field_db(input logic [2:0] f);
        logic [3:0] db;
        db = 4'h0;
        if (f[2])
            db = GAIN_MAX_DB;
        else
            db = 4'(GAIN_STEP_DB * {2'h0, f[1:0]});
        return db;
    endfunction

    logic       chen;
    logic       pol_eff;
    logic       dspace_eff;
    logic [2:0] foll_eff;
    logic [1:0] fmt_eff;
    logic       sclk_rise;
    logic       wrap;
    logic       ring_level;
    logic [5:0] spacing;
    logic       rd_line;
    logic       rd_rev;
    logic       clr_link;

    assign chen       = st_r.chain[CHEN_BIT];
    assign pol_eff    = chen & st_r.chain[POLARITY_BIT];
    assign dspace_eff = chen & st_r.chain[DSPACE_BIT];
    assign foll_eff   = chen ? st_r.chain[FOLL_LSB +: 3] : 3'h0;
    assign fmt_eff    = chen ? st_r.chain[FMT_LSB +: 2] : 2'h0;

    assign spacing   = dspace_eff ? SPACING_DELAYED : SPACING_NORMAL;
    assign sclk_rise = st_r.sclk_prev == 1'b0 && sclk_s == 1'b1;
    assign wrap      = sclk_rise && {1'b0, st_r.bitcnt} == spacing - 6'h01;

    assign ring_level = pol_eff ? ring_s : ~ring_s;

    assign rd_line  = RD_I && ADDR_I == LINE_STATUS_OFS;
    assign rd_rev   = RD_I && ADDR_I == REV_GAIN_OFS;
    assign clr_link = WR_I && ADDR_I == LINE_STATUS_OFS && !WDATA_I[LINK_ERR_BIT];

    always_comb
    begin
        logic [IRQ_W-1:0] ev;
        ev     = '0;
        st_nxt = st_r;

        case (st_r.fsm)
            ST_STRAP:
            begin
                st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
                if (st_r.strap_cnt == SYNC_STAGES)
                begin
                    st_nxt.fsm = ST_RUN;
                    if (mode_s == SERIAL_MODE2)
                        st_nxt.chain = CHAIN_RST_M2;
                end
            end
            ST_RUN:
                st_nxt.strap_cnt = st_r.strap_cnt;
            default:
                st_nxt.fsm = ST_STRAP;
        endcase

        // Register writes
        if (WR_I)
        begin
            case (ADDR_I)
                REV_GAIN_OFS:   st_nxt.legacy   = WDATA_I[1:0];
                CHAIN_CTRL_OFS: st_nxt.chain    = WDATA_I;
                IRQ_MASK_OFS:   st_nxt.irq_mask = WDATA_I[IRQ_W-1:0];
                default:        st_nxt.legacy   = st_nxt.legacy;
            endcase
        end

        // sticky link error, set wins over clear
        if (clr_link)
            st_nxt.link_err = 1'b0;
        if (fault_s)
            st_nxt.link_err = 1'b1;

        // Events for the interrupt status
        st_nxt.lock_prev = lock_s;
        st_nxt.ring_prev = ring_s;
        ev[IRQ_LINK_ERR] = fault_s & ~st_r.link_err;
        ev[IRQ_LOCK_CHG] = lock_s ^ st_r.lock_prev;
        ev[IRQ_RING]     = ring_s & ~st_r.ring_prev;

        // Read data, one cycle later; unmapped reads return zero
        st_nxt.rdata = 8'h00;
        if (RD_I)
        begin
            case (ADDR_I)
                LINE_STATUS_OFS: st_nxt.rdata = {st_r.link_err, lock_s, 2'h0, loop_s};
                REV_GAIN_OFS:    st_nxt.rdata = {1'b0, intl_s, rev_s, st_r.legacy};
                CHAIN_CTRL_OFS:  st_nxt.rdata = st_r.chain;
                IRQ_STATUS_OFS:  st_nxt.rdata = 8'(st_r.irq_stat);
                IRQ_MASK_OFS:    st_nxt.rdata = 8'(st_r.irq_mask);
                default:         st_nxt.rdata = 8'h00;
            endcase
        end

        // Read clears status; a new event in the same cycle survives
        if (RD_I && ADDR_I == IRQ_STATUS_OFS)
            st_nxt.irq_stat = ev;
        else
            st_nxt.irq_stat = st_r.irq_stat | ev;

        st_nxt.sclk_prev = sclk_s;
        if (sclk_rise)
        begin
            st_nxt.fsync = 1'b0;
            st_nxt.dsync = 1'b0;
            if (wrap)
            begin
                st_nxt.bitcnt = 5'h00;
                if (st_r.slot >= foll_eff)
                    st_nxt.slot = 3'h0;
                else
                    st_nxt.slot = st_r.slot + 3'h1;
                st_nxt.fsync = st_nxt.slot == 3'h0;
                st_nxt.dsync = st_nxt.slot != 3'h0;
            end
            else
                st_nxt.bitcnt = st_r.bitcnt + 5'h01;
        end

        case (fmt_eff)
            FMT_LSB1: st_nxt.out_word = {RX_WORD_I[15:1], 1'b1};
            FMT_LSB0: st_nxt.out_word = {RX_WORD_I[15:1], 1'b0};
            default:  st_nxt.out_word = RX_WORD_I;
        endcase

        st_nxt.rx_db = st_r.legacy[RXG_BIT] ? LEGACY_RX_DB : field_db(RX_GAIN_FIELD_I);
        st_nxt.tx_db = st_r.legacy[TXA_BIT] ? LEGACY_TX_DB : field_db(TX_ATTEN_FIELD_I);

        st_nxt.ring_oe   = chen;
        st_nxt.ring_pin  = chen & ring_level;
        st_nxt.dsync_pin = chen ? st_r.dsync : ring_level;
        st_nxt.fctrl     = ~chen & fctrl_s;
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            st_r       <= '0;
            st_r.fsm   <= ST_STRAP;
            st_r.chain <= CHAIN_RST_M01;
        end
        else
            st_r <= st_nxt;
    end

    assign RDATA_O              = st_r.rdata;
    assign IRQ_O                = |(st_r.irq_stat & st_r.irq_mask);
    assign SERIAL_OUT_DATA_O    = st_r.out_word;
    assign RX_GAIN_DB_O         = st_r.rx_db;
    assign TX_ATTEN_DB_O        = st_r.tx_db;
    assign FSYNC_O              = st_r.fsync;
    assign RING_DETECT_PIN_O    = st_r.ring_pin;
    assign RING_DETECT_PIN_OE_O = st_r.ring_oe;
    assign DELAYED_SYNC_PIN_O   = st_r.dsync_pin;
    assign FRAME_CTRL_O         = st_r.fctrl;

    // ****************************************
    // Assertions
    // ****************************************
    property p_link_set;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        fault_s |=> st_r.link_err ##1 (st_r.link_err || $past(clr_link));
    endproperty
    a_link_set: assert property (p_link_set) else $error("link error not held");

    property p_lock_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        rd_line |=> RDATA_O[LOCK_BIT] == $past(lock_s) && RDATA_O[5:4] == 2'h0;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock flag read wrong");

    property p_loop_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        rd_line |=> RDATA_O[3:0] == $past(loop_s);
    endproperty
    a_loop_read: assert property (p_loop_read) else $error("loop level read wrong");

    property p_rev_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        rd_rev |=> RDATA_O[INTL_BIT:REV_LSB] == $past({intl_s, rev_s}) && !RDATA_O[7];
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

    property p_rx_gain;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        st_r.legacy[RXG_BIT] |=> RX_GAIN_DB_O == 4'h6;
    endproperty
    a_rx_gain: assert property (p_rx_gain) else $error("legacy rx gain not 6 dB");

    property p_tx_atten;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        (st_r.legacy[TXA_BIT] ##1 st_r.legacy[TXA_BIT]) |-> TX_ATTEN_DB_O == 4'h3;
    endproperty
    a_tx_atten: assert property (p_tx_atten) else $error("legacy tx atten not 3 dB");

    property p_chain_off;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        !chen [*2] |-> !RING_DETECT_PIN_OE_O && !RING_DETECT_PIN_O
            && DELAYED_SYNC_PIN_O == $past(!ring_s) && FRAME_CTRL_O == $past(fctrl_s);
    endproperty
    a_chain_off: assert property (p_chain_off) else $error("chain fields not ignored");

    property p_spacing;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        wrap |-> st_r.bitcnt == (dspace_eff ? 5'h0f : 5'h1f);
    endproperty
    a_spacing: assert property (p_spacing) else $error("frame sync spacing wrong");

    property p_intl_read;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        rd_rev |=> RDATA_O[INTL_BIT] == $past(intl_s) && RDATA_O[1:0] == $past(st_r.legacy);
    endproperty
    a_intl_read: assert property (p_intl_read) else $error("capability bit read wrong");

    property p_ring_pol;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        chen |=> RING_DETECT_PIN_OE_O
            && RING_DETECT_PIN_O == ($past(st_r.chain[POLARITY_BIT]) ? $past(ring_s) : !$past(ring_s));
    endproperty
    a_ring_pol: assert property (p_ring_pol) else $error("ring pin polarity wrong");

    property p_chain_sync;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        chen |=> DELAYED_SYNC_PIN_O == $past(st_r.dsync);
    endproperty
    a_chain_sync: assert property (p_chain_sync) else $error("delayed sync pin wrong");

    property p_format;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        chen && st_r.chain[FMT_LSB + 1] |=> SERIAL_OUT_DATA_O[15:1] == $past(RX_WORD_I[15:1])
            && SERIAL_OUT_DATA_O[0] == !$past(st_r.chain[FMT_LSB]);
    endproperty
    a_format: assert property (p_format) else $error("receive word format wrong");

    property p_strap;
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $rose(st_r.fsm == ST_RUN) && $past(mode_s) == SERIAL_MODE2 && !$past(WR_I)
            |-> st_r.chain == CHAIN_RST_M2;
    endproperty
    a_strap: assert property (p_strap) else $error("mode 2 chain reset wrong");

endmodule

/* File: verilog/daa_pkg.sv */
// Functional notes
// - Link error flag, bit 7, sets on link fault; cleared by writing 0.
// - Frame lock flag, bit 6, reads 1 while the link holds frame lock.
// - Four-bit loop current level in 6 mA steps, 0 to 1111.
// - Read-only bit 6 of revision register: 1 means international line-side chip.
// - Revision register bits 5:2 return the line-side chip revision, read-only.
// - Legacy receive gain bit 1 set gives 6 dB receive gain, else 0 dB; when clear the code uses the extended receive gain field.
// - Legacy transmit bit 0 set gives 3 dB transmit attenuation, else 0 dB; when clear the code uses the extended transmit field.
// - Follower count bits 7:5 give 0 to 7 followers; 0 only reassigns pins.
// - Format field: 00 16-bit, 10 15-bit LSB 1, 11 15-bit LSB 0.
// - Frame syncs 32 serial clocks apart, or 16 with delayed spacing set.
// - Ring detect pin active low with polarity 0, active high with 1.
// - Chain enable turns shared pins into ring detect and delayed sync outputs.
// - With chain enable 0 all other chain control fields are ignored.
// - Chain control resets to 0x02 in serial modes 0, 1 and 0x3f in mode 2.
// - Extended gain fields select 0 to 12 dB in 3 dB steps.
package daa_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] LINE_STATUS_OFS = 8'h0c;
    localparam logic [7:0] REV_GAIN_OFS    = 8'h0d;
    localparam logic [7:0] CHAIN_CTRL_OFS  = 8'h0e;
    localparam logic [7:0] IRQ_STATUS_OFS  = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h11;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int LINK_ERR_BIT = 7;
    localparam int LOCK_BIT     = 6;
    localparam int INTL_BIT     = 6;
    localparam int REV_LSB      = 2;
    localparam int RXG_BIT      = 1;
    localparam int TXA_BIT      = 0;
    localparam int FOLL_LSB     = 5;
    localparam int FMT_LSB      = 3;
    localparam int DSPACE_BIT   = 2;
    localparam int POLARITY_BIT = 1;
    localparam int CHEN_BIT     = 0;
    localparam int IRQ_LINK_ERR = 0;
    localparam int IRQ_LOCK_CHG = 1;
    localparam int IRQ_RING     = 2;
    localparam int IRQ_W        = 3;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [7:0] CHAIN_RST_M01 = 8'h02;
    localparam logic [7:0] CHAIN_RST_M2  = 8'h3f;
    localparam logic [1:0] SERIAL_MODE2  = 2'h2;
    localparam logic [1:0] FMT_LSB1      = 2'h2;
    localparam logic [1:0] FMT_LSB0      = 2'h3;

    // ****************************************
    // Counts and gains
    // ****************************************
    localparam logic [5:0] SPACING_NORMAL  = 6'h20;
    localparam logic [5:0] SPACING_DELAYED = 6'h10;
    localparam logic [1:0] SYNC_STAGES     = 2'h2;
    localparam logic [3:0] LEGACY_RX_DB    = 4'h6;
    localparam logic [3:0] LEGACY_TX_DB    = 4'h3;
    localparam logic [3:0] GAIN_STEP_DB    = 4'h3;
    localparam logic [3:0] GAIN_MAX_DB     = 4'hc;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b10
    } init_state_t;

endpackage

/* File: verilog/daa_pin_sync.sv */
module daa_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // First stage feeds only the second stage
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d_i;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q_o = st_r.s2;

endmodule

/* File: dv/dsp_port_model.sv */
module dsp_port_model (
    output logic sclk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Free-running bit clock; the offset keeps its edges off the system clock edges
    initial
    begin
        sclk_o = 1'b0;
        #7;
        forever
        begin
            #160 sclk_o = ~sclk_o;
        end
    end
endmodule

/* File: dv/daa_status_chain_regs_bench.sv */
module daa_status_chain_regs_bench import daa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rstn, wr_s, rd_s, irq, sclk, fault, ring, pin_in;
    logic [7:0]  addr, wdata, rdata;
    logic [1:0]  mode;
    logic [2:0]  rx_f, tx_f;
    logic [15:0] word, out_w;
    logic        lock, intl;
    logic [3:0]  loop, rev;
    logic [3:0]  rx_db, tx_db;
    logic        fsync, rd_pin, rd_oe, ds_pin, fctl;
    int          err_count, check_count;

    dsp_port_model u_dsp (.sclk_o(sclk));
    daa_status_chain_regs u_dut (
        .CLOCK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .IRQ_O(irq), .SCLK_I(sclk), .LINK_FAULT_I(fault),
        .FRAME_LOCK_I(lock), .LOOP_CURRENT_I(loop), .INTL_SUPPORT_I(intl),
        .LINE_REV_I(rev), .RING_I(ring), .SERIAL_MODE_I(mode), .RX_GAIN_FIELD_I(rx_f),
        .TX_ATTEN_FIELD_I(tx_f), .RX_WORD_I(word), .SERIAL_OUT_DATA_O(out_w),
        .RX_GAIN_DB_O(rx_db), .TX_ATTEN_DB_O(tx_db), .FSYNC_O(fsync),
        .RING_DETECT_PIN_I(pin_in), .RING_DETECT_PIN_O(rd_pin),
        .RING_DETECT_PIN_OE_O(rd_oe), .DELAYED_SYNC_PIN_O(ds_pin), .FRAME_CTRL_O(fctl));

    always #20 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = {8'h00, rdata};
    endtask

    task automatic t_reset();
        logic [15:0] d;
        rd(CHAIN_CTRL_OFS, d);
        chk(d, 16'h0002);
        rd(LINE_STATUS_OFS, d);
        chk(d, 16'h004f);
        rd(REV_GAIN_OFS, d);
        chk(d, 16'h0068);
        rd(8'h12, d);
        chk(d, 16'h0000);
        rd(IRQ_STATUS_OFS, d);
    endtask

    task automatic t_line();
        logic [15:0] d;
        @(posedge clk);
        lock <= 1'b0;
        intl <= 1'b0;
        loop <= 4'h5;
        rev <= 4'h3;
        cyc(4);
        rd(LINE_STATUS_OFS, d);
        chk(d, 16'h0005);
        rd(REV_GAIN_OFS, d);
        chk(d, 16'h000c);
        @(posedge clk);
        {lock, intl, loop, rev} <= {1'b1, 1'b1, 4'hf, 4'ha};
        cyc(4);
        // Lock lost and regained: both edges land in the lock change bit
        rd(IRQ_STATUS_OFS, d);
        chk(d, 16'h0002);
    endtask

    task automatic t_link_irq();
        logic [15:0] d;
        wr(IRQ_MASK_OFS, 8'h00);
        @(posedge clk);
        fault <= 1'b1;
        cyc(6);
        chk({15'h0, irq}, 16'h0000);
        @(posedge clk);
        fault <= 1'b0;
        cyc(4);
        wr(IRQ_MASK_OFS, 8'h01);
        cyc(1);
        chk({15'h0, irq}, 16'h0001);
        wr(LINE_STATUS_OFS, 8'h80);
        rd(LINE_STATUS_OFS, d);
        chk(d, 16'h00cf);
        rd(IRQ_STATUS_OFS, d);
        chk(d, 16'h0001);
        cyc(1);
        chk({15'h0, irq}, 16'h0000);
        wr(LINE_STATUS_OFS, 8'h00);
        rd(LINE_STATUS_OFS, d);
        chk(d, 16'h004f);
    endtask

    task automatic t_gain();
        logic [15:0] d;
        @(posedge clk);
        rx_f <= 3'h4;
        tx_f <= 3'h3;
        wr(REV_GAIN_OFS, 8'h00);
        cyc(2);
        chk({12'h0, rx_db}, 16'h000c);
        chk({12'h0, tx_db}, 16'h0009);
        wr(REV_GAIN_OFS, 8'hff);
        cyc(2);
        chk({12'h0, rx_db}, 16'h0006);
        chk({12'h0, tx_db}, 16'h0003);
        rd(REV_GAIN_OFS, d);
        chk(d, 16'h006b);
        // Legacy bits back to zero while the extended fields are in use
        wr(REV_GAIN_OFS, 8'h00);
    endtask

    task automatic t_format();
        logic [7:0]  c[4] = '{8'h18, 8'h19, 8'h11, 8'h01};
        logic [15:0] w[4] = '{16'h1235, 16'h1235, 16'h1234, 16'h1234};
        logic [15:0] e[4] = '{16'h1235, 16'h1234, 16'h1235, 16'h1234};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            word <= w[i];
            wr(CHAIN_CTRL_OFS, c[i]);
            cyc(2);
            chk(out_w, e[i]);
        end
    endtask

    task automatic t_ring();
        logic [15:0] d;
        @(posedge clk);
        ring <= 1'b1;
        pin_in <= 1'b1;
        wr(CHAIN_CTRL_OFS, 8'h00);
        cyc(5);
        chk({13'h0, rd_oe, ds_pin, fctl}, 16'h0001);
        wr(CHAIN_CTRL_OFS, 8'h01);
        cyc(3);
        chk({14'h0, rd_oe, rd_pin}, 16'h0002);
        wr(CHAIN_CTRL_OFS, 8'h03);
        cyc(3);
        chk({14'h0, rd_oe, rd_pin}, 16'h0003);
        @(posedge clk);
        ring <= 1'b0;
        rd(IRQ_STATUS_OFS, d);
        chk(d, 16'h0004);
    endtask

    task automatic wait_lvl(input logic v, inout int k, inout int h);
        while (fsync !== v && k < 4000)
        begin
            @(posedge clk);
            #1;
            k++;
            if (ds_pin === 1'b1)
                h++;
        end
    endtask

    task automatic t_sync();
        logic [7:0]  c[5] = '{8'h00, 8'h04, 8'h05, 8'h45, 8'h85};
        logic [15:0] e[5] = '{16'h0100, 16'h0100, 16'h0080, 16'h0180, 16'h0280};
        logic [15:0] g[5] = '{16'h0100, 16'h0100, 16'h0000, 16'h0010, 16'h0020};
        int k, s, h;
        for (int i = 0; i < 5; i++)
        begin
            // Four followers only with the short spacing, as the chain requires
            wr(CHAIN_CTRL_OFS, c[i]);
            k = 0;
            h = 0;
            wait_lvl(1'b0, k, h);
            wait_lvl(1'b1, k, h);
            wait_lvl(1'b0, k, h);
            s = k;
            h = 0;
            wait_lvl(1'b1, k, h);
            wait_lvl(1'b0, k, h);
            chk(16'(k - s), e[i]);
            // Chain off: pin shows idle ring detect; chain on: one bit slot per follower
            chk(16'(h), g[i]);
        end
    endtask

    task automatic t_mode2();
        logic [15:0] d;
        @(posedge clk);
        rstn <= 1'b0;
        mode <= SERIAL_MODE2;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        cyc(10);
        rd(CHAIN_CTRL_OFS, d);
        chk(d, 16'h003f);
    endtask

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        {clk, rstn, wr_s, rd_s, fault, ring, pin_in} = '0;
        {addr, wdata, mode, rx_f, tx_f, word} = '0;
        {lock, intl, loop, rev} = {1'b1, 1'b1, 4'hf, 4'ha};
        err_count = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        cyc(5);
        t_reset();
        t_line();
        t_link_irq();
        t_gain();
        t_format();
        t_ring();
        t_sync();
        t_mode2();
        summarize();
    end

    // A hang anywhere ends the run with a failure instead of stalling it
    initial
    begin
        #(40 * 40000);
        err_count++;
        summarize();
    end
endmodule
